// *** rtl/adcfw_defines.svh ***
/*
 * Shared constants of the four-wire converter readout: widths, times, margins.
 * Assumes a single system clock whose rate is given in MHz below.
 */
`ifndef ADCFW_DEFINES_SVH
`define ADCFW_DEFINES_SVH

`define ADCFW_RESULT_W      18
`define ADCFW_STATUS_W      6
`define ADCFW_SYS_MHZ       250
`define ADCFW_CONV_MIN_NS   200
`define ADCFW_CONV_MAX_NS   280
`define ADCFW_QUIET_READ_NS 20
`define ADCFW_QUIET_NEXT_NS 60
`define ADCFW_SCK_PERIOD_NS 80
`define ADCFW_SYNC_MARGIN   6
`define ADCFW_BUSY_SEL_AT   1
`define ADCFW_TIMER_W       16
`define ADCFW_PULL_LEVEL    1'b1
`define ADCFW_CYC_UP(ns, mhz) ((((ns) * (mhz)) + 999) / 1000)
`define ADCFW_CYC_DN(ns, mhz) (((ns) * (mhz)) / 1000)

`endif

// *** rtl/adcfw_pkg.sv ***
/*
 * Types of the four-wire converter readout: state encodings of both ends.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package adcfw_pkg;

	// Gray along acquire, early conversion, late conversion
	typedef enum logic [1:0] {
		ADCFW_ACQ  = 2'b00,
		ADCFW_CONV = 2'b01,
		ADCFW_LATE = 2'b11
	} adcfw_conv_t;

	// Gray along idle, wait, read, tail
	typedef enum logic [1:0] {
		ADCFW_H_IDLE = 2'b00,
		ADCFW_H_WAIT = 2'b01,
		ADCFW_H_READ = 2'b11,
		ADCFW_H_TAIL = 2'b10
	} adcfw_host_t;

endpackage

// *** rtl/adcfw_if.sv ***
/*
 * Link between host and converter: start line, select, serial clock, data.
 * Assumes a pull-up on the data line; the wire level is resolved here.
 */
`timescale 1ns/1ns
`include "adcfw_defines.svh"

interface adcfw_if;
	logic convert_start;
	logic select_in;
	logic sck;
	logic serial_out;
	logic serial_out_oe;
	logic serial_line;

	// Pull-up holds the line high while the converter floats it
	assign serial_line = serial_out_oe ? serial_out : `ADCFW_PULL_LEVEL;

	modport dev (
		input  convert_start,
		input  select_in,
		input  sck,
		output serial_out,
		output serial_out_oe
	);

	modport host (
		output convert_start,
		output select_in,
		output sck,
		input  serial_line
	);
endinterface // adcfw_if

// *** rtl/adcfw_dev.sv ***
/*
 * Converter end of the four-wire readout: conversion timing, result hold,
 * serial shifter with chip-select, turbo and busy-indicator behaviour.
 * Assumes link pins are asynchronous to i_sys_clk and are resynchronised;
 * the sampled result and status words come from the converter core.
 */
`timescale 1ns/1ns
`include "adcfw_defines.svh"

// How it works
// - Host holds select high at start rise
// - Host keeps start high through conversion, readback
// - Turbo host waits quiet time before select
// - Turbo readout gives previous conversion result
// - Conversion end enters acquisition, powers down
// - Select falling presents result MSB at once
// - Result MSB first, one bit per fall
// - Status bits on falls 18 to 23, 19 to 24 in busy mode
// - Each bit stable across both clock edges
// - Turbo floats after last fall or start
// - Host leaves quiet time before next start
// - Start rise begins conversion, floats output
// - Host clears turbo setting for other modes
// - No-busy host returns select high early
// - Host keeps serial clock still during conversion; turbo host clocks the readout during it
// - No-busy floats after last fall or select
// - Host selects one device at a time
// - Busy host holds select low through conversion
// - Busy mode drives output low at completion
// - Busy floats after extra fall or start
// - Host enables turbo by a configuration write

module adcfw_dev
	import adcfw_pkg::*;
#(
	parameter int RESULT_W    = `ADCFW_RESULT_W,
	parameter int STATUS_W    = `ADCFW_STATUS_W,
	parameter int SYS_MHZ     = `ADCFW_SYS_MHZ,
	parameter int CONV_MIN_NS = `ADCFW_CONV_MIN_NS,
	parameter int CONV_MAX_NS = `ADCFW_CONV_MAX_NS
) (
	input  wire logic                i_sys_clk,
	input  wire logic                i_rst_n,
	input  wire logic                i_turbo,
	input  wire logic                i_status_en,
	input  wire logic [RESULT_W-1:0] i_sample,
	input  wire logic [STATUS_W-1:0] i_status,
	output logic                     o_converting,
	output logic                     o_powered_down,
	adcfw_if.dev                     link
);

	// ************************************************************
	// Derived sizes and times
	// ************************************************************
	localparam int TOTAL    = RESULT_W + STATUS_W;
	localparam int BIT_W    = $clog2(TOTAL + 1);
	localparam int MIN_CYC  = `ADCFW_CYC_UP(CONV_MIN_NS, SYS_MHZ);
	localparam int DONE_CYC = `ADCFW_CYC_DN(CONV_MAX_NS, SYS_MHZ);
	localparam int CNT_W    = $clog2(DONE_CYC + 1);

	localparam logic [CNT_W-1:0] MIN_AT   = CNT_W'(MIN_CYC - 1);
	localparam logic [CNT_W-1:0] DONE_AT  = CNT_W'(DONE_CYC - 1);
	localparam logic [BIT_W-1:0] LEN_FULL = BIT_W'(TOTAL);
	localparam logic [BIT_W-1:0] LEN_RES  = BIT_W'(RESULT_W);

	if (RESULT_W < 2 || STATUS_W < 1 || MIN_CYC < 1 || DONE_CYC <= MIN_CYC) begin : g_bad
		$error("adcfw_dev: widths or conversion times unusable");
	end

	// ************************************************************
	// Pin synchronisers and edge detection
	// ************************************************************
	logic [2:0] start_sync;
	logic [2:0] sel_sync;
	logic [2:0] sck_sync;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			start_sync <= 3'h0;
			sel_sync   <= 3'h7;
			sck_sync   <= 3'h0;
		end else begin
			start_sync <= {start_sync[1:0], link.convert_start};
			sel_sync   <= {sel_sync[1:0], link.select_in};
			sck_sync   <= {sck_sync[1:0], link.sck};
		end
	end

	logic start_rise;
	logic sel_q;
	logic sel_fall;
	logic sel_rise;
	logic sck_fall;

	assign start_rise = start_sync[1] & ~start_sync[2];
	assign sel_q      = sel_sync[1];
	assign sel_fall   = ~sel_sync[1] & sel_sync[2];
	assign sel_rise   = sel_sync[1] & ~sel_sync[2];
	assign sck_fall   = ~sck_sync[1] & sck_sync[2];

	// ************************************************************
	// Conversion timing and result hold
	// ************************************************************
	adcfw_conv_t         conv_state;
	adcfw_conv_t         next_conv_state;
	logic [CNT_W-1:0]    conv_cnt;
	logic [CNT_W-1:0]    next_conv_cnt;
	logic                busy_sel;
	logic                next_busy_sel;
	logic [RESULT_W-1:0] result;
	logic [RESULT_W-1:0] next_result;
	logic [STATUS_W-1:0] status_hold;
	logic [STATUS_W-1:0] next_status_hold;
	logic                next_converting;
	logic                conv_done;

	assign conv_done = (conv_state == ADCFW_LATE) && (conv_cnt == DONE_AT);

	always_comb begin
		next_conv_state  = conv_state;
		next_conv_cnt    = conv_cnt;
		next_busy_sel    = busy_sel;
		next_result      = result;
		next_status_hold = status_hold;
		case (conv_state)
			ADCFW_ACQ: begin
				if (start_rise) begin
					next_conv_state = ADCFW_CONV;
					next_conv_cnt   = '0;
					next_busy_sel   = 1'b0;
				end
			end
			ADCFW_CONV: begin
				next_conv_cnt = conv_cnt + 1'b1;
				if (conv_cnt == MIN_AT) begin
					next_conv_state = ADCFW_LATE;
					// Select low at this point asks for the busy indicator
					next_busy_sel   = ~i_turbo & ~sel_q;
				end
			end
			ADCFW_LATE: begin
				next_conv_cnt = conv_cnt + 1'b1;
				if (conv_done) begin
					// Back to acquisition; core powers down meanwhile
					next_conv_state  = ADCFW_ACQ;
					next_result      = i_sample;
					next_status_hold = i_status;
				end
			end
			default: begin
				next_conv_state = ADCFW_ACQ;
			end
		endcase
		next_converting = (next_conv_state != ADCFW_ACQ);
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			conv_state     <= ADCFW_ACQ;
			conv_cnt       <= '0;
			busy_sel       <= 1'b0;
			result         <= '0;
			status_hold    <= '0;
			o_converting   <= 1'b0;
			o_powered_down <= 1'b1;
		end else begin
			conv_state     <= next_conv_state;
			conv_cnt       <= next_conv_cnt;
			busy_sel       <= next_busy_sel;
			result         <= next_result;
			status_hold    <= next_status_hold;
			o_converting   <= next_converting;
			o_powered_down <= ~next_converting;
		end
	end

	// ************************************************************
	// Serial shifter and output drive
	// ************************************************************
	logic [TOTAL-1:0] shift;
	logic [TOTAL-1:0] next_shift;
	logic [BIT_W-1:0] bit_cnt;
	logic [BIT_W-1:0] next_bit_cnt;
	logic             dout;
	logic             next_dout;
	logic             oe;
	logic             next_oe;
	logic [TOTAL-1:0] held_stream;
	logic [TOTAL-1:0] fresh_stream;
	logic [BIT_W-1:0] len;

	// Status bits ride behind the result only when enabled
	assign held_stream  = {result, i_status_en ? status_hold : {STATUS_W{1'b0}}};
	assign fresh_stream = {i_sample, i_status_en ? i_status : {STATUS_W{1'b0}}};
	assign len          = i_status_en ? LEN_FULL : LEN_RES;

	always_comb begin
		next_shift   = shift;
		next_bit_cnt = bit_cnt;
		next_dout    = dout;
		next_oe      = oe;
		if (start_rise) begin
			next_oe = 1'b0;
		end else if (conv_done && busy_sel) begin
			// Low level on the pulled-up line acts as the host interrupt
			next_oe      = 1'b1;
			next_dout    = 1'b0;
			next_shift   = fresh_stream;
			next_bit_cnt = '0;
		end else if (sel_fall && !busy_sel && (i_turbo || conv_state == ADCFW_ACQ)) begin
			// In turbo the held word is still the previous conversion
			next_oe      = 1'b1;
			next_dout    = held_stream[TOTAL-1];
			next_shift   = {held_stream[TOTAL-2:0], 1'b0};
			next_bit_cnt = BIT_W'(1);
		end else if (sel_rise && !i_turbo && !busy_sel) begin
			next_oe = 1'b0;
		end else if (sck_fall && oe) begin
			if (bit_cnt == len) begin
				next_oe = 1'b0;
			end else begin
				// Data moves only on a falling edge, so it spans both edges
				next_dout    = shift[TOTAL-1];
				next_shift   = {shift[TOTAL-2:0], 1'b0};
				next_bit_cnt = bit_cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			shift   <= '0;
			bit_cnt <= '0;
			dout    <= 1'b0;
			oe      <= 1'b0;
		end else begin
			shift   <= next_shift;
			bit_cnt <= next_bit_cnt;
			dout    <= next_dout;
			oe      <= next_oe;
		end
	end

	assign link.serial_out    = dout;
	assign link.serial_out_oe = oe;

endmodule // adcfw_dev

// *** rtl/adcfw_host.sv ***
/*
 * Host end of the four-wire readout: start line, select, divided serial
 * clock, and capture of result and status words.
 * Assumes the converter is configured to the mode given on i_turbo.
 */
`timescale 1ns/1ns
`include "adcfw_defines.svh"

module adcfw_host
	import adcfw_pkg::*;
#(
	parameter int RESULT_W      = `ADCFW_RESULT_W,
	parameter int STATUS_W      = `ADCFW_STATUS_W,
	parameter int SYS_MHZ       = `ADCFW_SYS_MHZ,
	parameter int CONV_MAX_NS   = `ADCFW_CONV_MAX_NS,
	parameter int QUIET_READ_NS = `ADCFW_QUIET_READ_NS,
	parameter int QUIET_NEXT_NS = `ADCFW_QUIET_NEXT_NS,
	parameter int SCK_PERIOD_NS = `ADCFW_SCK_PERIOD_NS
) (
	input  wire logic                i_sys_clk,
	input  wire logic                i_rst_n,
	input  wire logic                i_start,
	input  wire logic                i_turbo,
	input  wire logic                i_busy_mode,
	input  wire logic                i_status_en,
	output logic                     o_idle,
	output logic                     o_valid,
	output logic [RESULT_W-1:0]      o_result,
	output logic [STATUS_W-1:0]      o_status,
	adcfw_if.host                    link
);

	// ************************************************************
	// Derived sizes and waits
	// ************************************************************
	localparam int TOTAL  = RESULT_W + STATUS_W;
	localparam int BIT_W  = $clog2(TOTAL + 2);
	localparam int TW     = `ADCFW_TIMER_W;
	localparam int HALF   = `ADCFW_CYC_UP(SCK_PERIOD_NS / 2, SYS_MHZ);
	localparam int Q1_CYC = `ADCFW_CYC_UP(QUIET_READ_NS, SYS_MHZ) + `ADCFW_SYNC_MARGIN;
	localparam int CV_CYC = `ADCFW_CYC_UP(CONV_MAX_NS, SYS_MHZ) + `ADCFW_SYNC_MARGIN;
	localparam int Q2_CYC = `ADCFW_CYC_UP(QUIET_NEXT_NS, SYS_MHZ);

	localparam logic [TW-1:0] HALF_AT = TW'(HALF - 1);
	localparam logic [TW-1:0] Q1_AT   = TW'(Q1_CYC);
	localparam logic [TW-1:0] CV_AT   = TW'(CV_CYC);
	localparam logic [TW-1:0] Q2_AT   = TW'(Q2_CYC);
	localparam logic [TW-1:0] SEL_AT  = TW'(`ADCFW_BUSY_SEL_AT);
	localparam logic [TW-1:0] IRQ_AT  = TW'(2 * `ADCFW_SYNC_MARGIN);

	// Half period must cover both synchroniser paths
	if (HALF < `ADCFW_SYNC_MARGIN + 2 || CV_CYC >= (1 << TW) || Q2_CYC < 1) begin : g_bad
		$error("adcfw_host: clock divider or waits unusable");
	end

	// ************************************************************
	// Data line synchroniser
	// ************************************************************
	logic [1:0] line_sync;
	logic       line_q;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			line_sync <= 2'h3;
		end else begin
			line_sync <= {line_sync[0], link.serial_line};
		end
	end

	assign line_q = line_sync[1];

	// ************************************************************
	// Sequencer
	// ************************************************************
	adcfw_host_t      st;
	adcfw_host_t      next_st;
	logic [TW-1:0]    cnt;
	logic [TW-1:0]    next_cnt;
	logic [TW-1:0]    hc;
	logic [TW-1:0]    next_hc;
	logic [BIT_W-1:0] per;
	logic [BIT_W-1:0] next_per;
	logic [TOTAL-1:0] rx;
	logic [TOTAL-1:0] next_rx;
	logic [2:0]       mode;
	logic [2:0]       next_mode;
	logic             start_line;
	logic             next_start_line;
	logic             sel;
	logic             next_sel;
	logic             sck;
	logic             next_sck;
	logic             next_valid;
	logic [RESULT_W-1:0] next_result;
	logic [STATUS_W-1:0] next_status;
	logic [BIT_W-1:0] periods;

	// Mode bits: turbo, busy, status enable, latched at start
	// Busy mode needs one extra period for the leading low bit
	assign periods = BIT_W'(mode[0] ? TOTAL : RESULT_W) + BIT_W'(mode[1]);

	always_comb begin
		next_st     = st;
		next_cnt    = (cnt == CV_AT) ? cnt : cnt + 1'b1;
		next_hc     = hc;
		next_per    = per;
		next_rx     = rx;
		next_mode   = mode;
		next_start_line = start_line;
		next_sel    = sel;
		next_sck    = sck;
		next_valid  = 1'b0;
		next_result = o_result;
		next_status = o_status;
		case (st)
			ADCFW_H_IDLE: begin
				next_sel        = 1'b1;
				next_start_line = 1'b0;
				next_sck        = 1'b0;
				if (i_start) begin
					next_st         = ADCFW_H_WAIT;
					next_start_line = 1'b1;
					next_cnt        = '0;
					// Turbo level must match the converter's setting
					next_mode = {i_turbo, i_busy_mode & ~i_turbo, i_status_en};
				end
			end
			ADCFW_H_WAIT: begin
				if (mode[2]) begin
					if (cnt == Q1_AT) begin
						next_sel = 1'b0;
					end
				end else if (mode[1]) begin
					if (cnt == SEL_AT) begin
						next_sel = 1'b0;
					end
				end else if (cnt == CV_AT) begin
					next_sel = 1'b0;
				end
				if ((mode[2] && cnt == Q1_AT) || (mode[1] && !line_q && cnt > IRQ_AT) ||
					(!mode[2] && !mode[1] && cnt == CV_AT)) begin
					next_st  = ADCFW_H_READ;
					next_hc  = '0;
					next_per = '0;
				end
			end
			ADCFW_H_READ: begin
				next_hc = hc + 1'b1;
				if (hc == HALF_AT) begin
					next_hc  = '0;
					next_sck = ~sck;
					if (!sck) begin
						next_rx = {rx[TOTAL-2:0], line_q};
					end else begin
						next_per = per + 1'b1;
						if (per + 1'b1 == periods) begin
							next_st     = ADCFW_H_TAIL;
							next_sel    = 1'b1;
							next_valid  = 1'b1;
							next_result = mode[0] ? rx[TOTAL-1 -: RESULT_W] : rx[RESULT_W-1:0];
							next_status = mode[0] ? rx[STATUS_W-1:0] : {STATUS_W{1'b0}};
						end
					end
				end
			end
			ADCFW_H_TAIL: begin
				next_hc = (hc == Q2_AT) ? hc : hc + 1'b1;
				// Start stays high until the conversion has surely ended
				if (hc == Q2_AT && cnt == CV_AT) begin
					next_st  = ADCFW_H_IDLE;
					next_start_line = 1'b0;
				end
			end
			default: begin
				next_st = ADCFW_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			st       <= ADCFW_H_IDLE;
			cnt      <= '0;
			hc       <= '0;
			per      <= '0;
			rx       <= '0;
			mode     <= 3'h0;
			start_line <= 1'b0;
			sel      <= 1'b1;
			sck      <= 1'b0;
			o_valid  <= 1'b0;
			o_idle   <= 1'b1;
			o_result <= '0;
			o_status <= '0;
		end else begin
			st       <= next_st;
			cnt      <= next_cnt;
			hc       <= next_hc;
			per      <= next_per;
			rx       <= next_rx;
			mode     <= next_mode;
			start_line <= next_start_line;
			sel      <= next_sel;
			sck      <= next_sck;
			o_valid  <= next_valid;
			o_idle   <= (next_st == ADCFW_H_IDLE);
			o_result <= next_result;
			o_status <= next_status;
		end
	end

	assign link.convert_start = start_line;
	assign link.select_in     = sel;
	assign link.sck           = sck;

endmodule // adcfw_host

// *** dv/adcfw_chk_sva.sv ***
/*
 * Checker of the converter link: pin relations sampled on the system clock.
 * Assumes it is instantiated beside the link interface, with its signals by name.
 */
`timescale 1ns/1ns

module adcfw_chk (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic convert_start,
	input wire logic select_in,
	input wire logic sck,
	input wire logic serial_out,
	input wire logic serial_out_oe,
	input wire logic serial_line
);
	// ****************************************
	// Helper counters
	// ****************************************
	logic       p_start;
	logic       p_sck;
	logic [7:0] since_start;
	logic [7:0] since_fall;
	logic [4:0] falls;
	logic       busy_arm;
	logic [7:0] next_since_start;
	logic [7:0] next_since_fall;
	logic [4:0] next_falls;
	logic       next_busy_arm;
	logic       start_rise;
	logic       sck_fall;

	// Counters saturate so long idle spans never wrap
	always_comb begin
		start_rise = convert_start && !p_start;
		sck_fall = !sck && p_sck;
		next_since_start = (since_start == 8'hff) ? since_start : since_start + 8'h01;
		next_since_fall = (since_fall == 8'hff) ? since_fall : since_fall + 8'h01;
		next_falls = (falls == 5'h1f) ? falls : falls + {4'h0, sck_fall};
		next_busy_arm = busy_arm;
		// Turbo is already driving here, so its low select is a read, not busy
		if (since_start == 8'h32) begin
			next_busy_arm = !select_in && !serial_out_oe;
		end
		if (start_rise) begin
			next_since_start = 8'h00;
			next_falls = 5'h00;
			next_busy_arm = 1'b0;
		end
		if (sck_fall) begin
			next_since_fall = 8'h00;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			p_start <= 1'b0;
			p_sck <= 1'b0;
			since_start <= 8'hff;
			since_fall <= 8'hff;
			falls <= 5'h00;
			busy_arm <= 1'b0;
		end else begin
			p_start <= convert_start;
			p_sck <= sck;
			since_start <= next_since_start;
			since_fall <= next_since_fall;
			falls <= next_falls;
			busy_arm <= next_busy_arm;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking dcb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	AST_START_SELECT_HIGH: assert property (
		$rose(convert_start) |-> select_in) else $error("start rose with select low");
	AST_START_HELD: assert property (
		$fell(convert_start) |-> !serial_out_oe && select_in) else $error("start fell early");
	AST_START_FLOATS: assert property (
		$rose(convert_start) |-> ##[1:6] !serial_out_oe) else $error("no float on start");
	AST_SELECT_DRIVES: assert property (
		$fell(select_in) && since_start > 8'h05 |-> ##[3:5] serial_out_oe)
		else $error("select fall did not drive");
	AST_SELECT_RISE_FLOATS: assert property (
		$rose(select_in) && !busy_arm |-> ##[1:6] !serial_out_oe)
		else $error("select rise did not float");
	AST_HOLD_OVER_RISE: assert property (
		$rose(sck) && serial_out_oe |-> $stable(serial_out) [*8])
		else $error("bit moved around rise");
	AST_HOLD_OVER_FALL: assert property (
		$fell(sck) && serial_out_oe |-> $stable(serial_out) [*3])
		else $error("bit moved at fall");
	AST_FALL_COUNT: assert property (
		$fell(serial_out_oe) |-> falls inside {5'h00, 5'h12, 5'h13, 5'h18, 5'h19})
		else $error("float after wrong fall count");
	AST_BUSY_LOW: assert property (
		$rose(serial_out_oe) && busy_arm |-> !serial_out && !serial_line)
		else $error("busy indicator not low");
	AST_BUSY_AT_END: assert property (
		$rose(serial_out_oe) && busy_arm |-> since_start >= 8'h44 && since_start <= 8'h50)
		else $error("busy indicator off conversion end");
	AST_NO_SCK_CONV: assert property (
		$rose(sck) && busy_arm |-> since_start > 8'h46) else $error("clock during conversion");
	// Counter lags the pin edge by one cycle, hence fourteen
	AST_QUIET_NEXT: assert property (
		$rose(convert_start) |-> since_fall >= 8'h0e) else $error("start too soon after fall");
endmodule // adcfw_chk

// *** dv/test_adc_four_wire_readout.sv ***
/*
 * Bench of the four-wire readout: host and converter ends joined by the link.
 * Assumes default parameters; the host turbo and converter turbo share one level.
 */
`timescale 1ns/1ns

module test_adc_four_wire_readout;
	// ****************************************
	// Signals and instances
	// ****************************************
	logic        i_sys_clk = 1'b0;
	logic        i_rst_n   = 1'b0;
	logic        start     = 1'b0;
	logic        turbo     = 1'b0;
	logic        busy      = 1'b0;
	logic        sts       = 1'b0;
	logic [17:0] sample    = 18'h00000;
	logic [5:0]  status    = 6'h00;
	logic        o_idle;
	logic        o_valid;
	logic [17:0] o_result;
	logic [5:0]  o_status;
	logic        o_converting;
	logic        o_powered_down;
	int          err_total = 0;
	int          n_checks  = 0;

	adcfw_if adcfw_if_i ();

	adcfw_dev adcfw_dev_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_turbo(turbo),
		.i_status_en(sts), .i_sample(sample), .i_status(status),
		.o_converting(o_converting), .o_powered_down(o_powered_down), .link(adcfw_if_i));

	adcfw_host adcfw_host_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_start(start),
		.i_turbo(turbo), .i_busy_mode(busy), .i_status_en(sts), .o_idle(o_idle),
		.o_valid(o_valid), .o_result(o_result), .o_status(o_status), .link(adcfw_if_i));

	adcfw_chk adcfw_chk_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.convert_start(adcfw_if_i.convert_start), .select_in(adcfw_if_i.select_in),
		.sck(adcfw_if_i.sck), .serial_out(adcfw_if_i.serial_out),
		.serial_out_oe(adcfw_if_i.serial_out_oe), .serial_line(adcfw_if_i.serial_line));

	// ****************************************
	// Tasks
	// ****************************************
	task end_sim();
		if (err_total == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task chk(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One conversion and readout; outputs sampled at the falling edge
	task run(input logic t, input logic b, input logic s, input logic [17:0] smp,
		input logic [5:0] st, input logic [17:0] er, input logic [5:0] es);
		int k;
		k = 0;
		while (o_idle !== 1'b1 && k < 200) begin
			@(negedge i_sys_clk);
			k++;
		end
		chk({23'h000000, adcfw_if_i.serial_out_oe}, 24'h000000);
		@(posedge i_sys_clk);
		turbo <= t;
		busy <= b;
		sts <= s;
		sample <= smp;
		status <= st;
		start <= 1'b1;
		@(posedge i_sys_clk);
		start <= 1'b0;
		repeat (20) @(negedge i_sys_clk);
		chk({23'h000000, o_converting}, 24'h000001);
		chk({23'h000000, adcfw_if_i.serial_out_oe}, {23'h000000, t});
		if (t) begin
			chk({23'h000000, adcfw_if_i.serial_line}, {23'h000000, er[17]});
		end
		k = 0;
		while (o_valid !== 1'b1 && k < 2000) begin
			@(negedge i_sys_clk);
			k++;
		end
		chk({23'h000000, o_valid}, 24'h000001);
		chk({6'h00, o_result}, {6'h00, er});
		if (s) begin
			chk({18'h00000, o_status}, {18'h00000, es});
		end
		chk({22'h000000, o_converting, o_powered_down}, 24'h000001);
	endtask

	// ****************************************
	// Clock, watchdog, tests
	// ****************************************
	initial begin
		forever #2 i_sys_clk = ~i_sys_clk;
	end

	// Seven readouts take near 14 us; four times that means a hang
	initial begin
		#60000;
		err_total++;
		end_sim();
	end

	initial begin
		repeat (12) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		repeat (2) @(posedge i_sys_clk);
		run(1'b0, 1'b0, 1'b0, 18'h2a5c3, 6'h00, 18'h2a5c3, 6'h00);
		run(1'b0, 1'b0, 1'b1, 18'h1ffff, 6'h2d, 18'h1ffff, 6'h2d);
		run(1'b0, 1'b1, 1'b0, 18'h3ffff, 6'h00, 18'h3ffff, 6'h00);
		run(1'b0, 1'b1, 1'b1, 18'h00001, 6'h3e, 18'h00001, 6'h3e);
		run(1'b1, 1'b0, 1'b1, 18'h15555, 6'h0a, 18'h00001, 6'h3e);
		run(1'b1, 1'b0, 1'b0, 18'h2aaaa, 6'h00, 18'h15555, 6'h0a);
		run(1'b0, 1'b0, 1'b0, 18'h00000, 6'h00, 18'h00000, 6'h00);
		end_sim();
	end
endmodule // test_adc_four_wire_readout
